// >>> rtl/t16cc_defines.svh
`ifndef T16CC_DEFINES_SVH
`define T16CC_DEFINES_SVH
// register offsets
`define T16CC_OFF_CTRL_B 8'h81
`define T16CC_OFF_CTRL_C 8'h82
`define T16CC_OFF_COUNT 8'h84
`define T16CC_OFF_CAPTURE 8'h86
`define T16CC_HIGH_STEP 8'h01
// control b fields
`define T16CC_B_FILTER 7
`define T16CC_B_EDGE 6
`define T16CC_B_MODE3 4
`define T16CC_B_MODE2 3
`define T16CC_B_CS_HI 2
`define T16CC_B_CS_LO 0
`define T16CC_B_WRITE_MASK 8'hDF
// control c fields
`define T16CC_C_FORCE_A 7
`define T16CC_C_FORCE_B 6
// reset values
`define T16CC_RST_CTRL_B 8'h00
`define T16CC_RST_WORD 16'h0000
// prescaler taps
`define T16CC_DIV8_MASK 10'h007
`define T16CC_DIV64_MASK 10'h03F
`define T16CC_DIV256_MASK 10'h0FF
`define T16CC_DIV1024_MASK 10'h3FF
// capture filter length
`define T16CC_FILTER_LEN 4
`endif

// >>> rtl/t16cc_pkg.sv
package t16cc_pkg;
   // clock select codes
   typedef enum logic [2:0] {
      T16CC_CS_STOP, T16CC_CS_DIV1, T16CC_CS_DIV8, T16CC_CS_DIV64,
      T16CC_CS_DIV256, T16CC_CS_DIV1024, T16CC_CS_EXT_FALL, T16CC_CS_EXT_RISE
   } t16cc_clksel_t;
   // one cpu i/o bus access
   typedef struct packed {
      logic [7:0] addr;
      logic wrEn;
      logic rdEn;
      logic [7:0] wrData;
   } t16cc_bus_t;
   // whole block state
   typedef struct packed {
      logic [7:0] ctrlB;
      logic [15:0] count;
      logic [15:0] capture;
      logic [7:0] temp;
      logic [9:0] pre;
      logic extSync1;
      logic extSync2;
      logic extPrev;
      logic capSync1;
      logic capSync2;
      logic [3:0] capHist;
      logic capFilt;
      logic capPrev;
      logic blockMatch;
      logic timerTick;
      logic captureFlag;
      logic captureEvent;
      logic forceA;
      logic forceB;
      logic [7:0] rdData;
   } t16cc_state_t;
endpackage

// >>> rtl/t16cc_timer.sv
// Overview of operation
// [R1] filter needs four equal capture samples
// [R2] edge bit: zero falling, one rising
// [R3] capture edge copies counter, sets flag
// [R4] capture off when capture register is top
// [R5] select 000 stops; 001-101 prescaled clock
// [R6] 110 external falling, 111 external rising
// [R7] force bits ignored in pwm modes
// [R8] force write gives immediate match strobe
// [R9] forced match: no flag, no clear
// [R10] force bits always read zero
// [R11] shared high-byte temp for 16-bit access
// [R12] counter write blocks next tick's match
// [R13] low byte base, high byte base+1
// [R14] software avoids counter writes while running
// [R15] flag cleared by vector or write one
// [R16] comparator may replace capture pin
// [R17] pins synchronised before edge detection
`timescale 1ns/100ps
`include "t16cc_defines.svh"
`default_nettype none
module t16cc_timer
   import t16cc_pkg::*;
#(
   parameter int FILTER_LEN = `T16CC_FILTER_LEN
) (
   input wire logic clk,
   input wire logic rst,
   input wire t16cc_bus_t bus,
   input wire logic [1:0] waveModeLow,
   input wire logic capturePin,
   input wire logic externalCountPin,
   input wire logic comparatorOut,
   input wire logic captureFromComparator,
   input wire logic captureVectorAck,
   input wire logic captureFlagWriteOne,
   output logic [7:0] rdData,
   output logic [15:0] counterValue,
   output logic [3:0] waveModeField,
   output logic timerTick,
   output logic matchBlock,
   output logic captureFlag,
   output logic captureEvent,
   output logic forceCompareA,
   output logic forceCompareB
);

   // filter history is four bits wide
   initial begin
      if (FILTER_LEN != 4) begin
         $error("t16cc_timer: FILTER_LEN must be 4");
      end
   end

   t16cc_state_t cur; // registered state
   t16cc_state_t nxt; // next state
   logic [3:0] mode; // full waveform mode
   logic tick; // counter clock enable this cycle
   logic extRise; // synced external pin rose
   logic extFall; // synced external pin fell
   logic capSrc; // chosen capture source
   logic capEdge; // qualified capture edge
   logic [15:0] word; // 16-bit write value
   logic [7:0] rdNext; // read mux result

   // prescaler tap test
   function automatic logic tapHit(
      input logic [9:0] pre,
      input logic [9:0] mask
   );
      tapHit = ((pre & mask) == mask);
   endfunction

   // counter clock for a select code
   function automatic logic clockTick(
      input t16cc_clksel_t sel,
      input logic [9:0] pre,
      input logic rise,
      input logic fall
   );
      unique case (sel)
         T16CC_CS_STOP: clockTick = 1'b0;
         T16CC_CS_DIV1: clockTick = 1'b1;
         T16CC_CS_DIV8: clockTick = tapHit(pre, `T16CC_DIV8_MASK);
         T16CC_CS_DIV64: clockTick = tapHit(pre, `T16CC_DIV64_MASK);
         T16CC_CS_DIV256: clockTick = tapHit(pre, `T16CC_DIV256_MASK);
         T16CC_CS_DIV1024: clockTick = tapHit(pre, `T16CC_DIV1024_MASK);
         T16CC_CS_EXT_FALL: clockTick = fall;
         T16CC_CS_EXT_RISE: clockTick = rise;
      endcase
   endfunction

   // modes where the capture register defines top
   function automatic logic captureIsTop(input logic [3:0] m);
      captureIsTop = (m == 4'h8) || (m == 4'hA) || (m == 4'hC) || (m == 4'hE);
   endfunction

   // modes that are not pwm
   function automatic logic nonPwm(input logic [3:0] m);
      nonPwm = (m == 4'h0) || (m == 4'h4) || (m == 4'hC);
   endfunction

   // address match for one register byte
   function automatic logic hitAt(input logic [7:0] a, input logic [7:0] off);
      hitAt = (a == off);
   endfunction

   // next-state logic
   always_comb begin
      nxt = cur;
      mode = {cur.ctrlB[`T16CC_B_MODE3], cur.ctrlB[`T16CC_B_MODE2], waveModeLow};
      // edges come only from synchronised copies
      extRise = cur.extSync2 & ~cur.extPrev; // [R17]
      extFall = ~cur.extSync2 & cur.extPrev; // [R17]
      tick = clockTick(t16cc_clksel_t'(cur.ctrlB[`T16CC_B_CS_HI:`T16CC_B_CS_LO]),
                       cur.pre, extRise, extFall); // [R5] [R6]
      word = {cur.temp, bus.wrData}; // [R11]
      rdNext = 8'h00;

      // free-running prescaler
      nxt.pre = cur.pre + 10'h001;

      // two-stage synchronisers
      nxt.extSync1 = externalCountPin; // [R17]
      nxt.extSync2 = cur.extSync1;
      nxt.extPrev = cur.extSync2;
      nxt.capSync1 = capturePin; // [R17]
      nxt.capSync2 = cur.capSync1;

      // noise filter over four samples
      nxt.capHist = {cur.capHist[2:0], cur.capSync2};
      if (cur.capHist == 4'hF) begin
         nxt.capFilt = 1'b1; // [R1]
      end else if (cur.capHist == 4'h0) begin
         nxt.capFilt = 1'b0; // [R1]
      end

      // capture source select
      if (captureFromComparator) begin
         capSrc = comparatorOut; // [R16]
      end else if (cur.ctrlB[`T16CC_B_FILTER]) begin
         capSrc = cur.capFilt; // [R1]
      end else begin
         capSrc = cur.capSync2;
      end
      nxt.capPrev = capSrc;

      // edge qualification
      if (cur.ctrlB[`T16CC_B_EDGE]) begin
         capEdge = capSrc & ~cur.capPrev; // [R2]
      end else begin
         capEdge = ~capSrc & cur.capPrev; // [R2]
      end
      capEdge = capEdge & ~captureIsTop(mode); // [R4]

      // counting and match blocking
      nxt.timerTick = tick;
      if (tick) begin
         nxt.count = cur.count + 16'h0001;
         nxt.blockMatch = 1'b0; // [R12]
      end

      // capture copies counter
      nxt.captureEvent = capEdge;
      if (capEdge) begin
         nxt.capture = cur.count; // [R3]
      end

      // capture flag: set wins over clear
      if (captureVectorAck || captureFlagWriteOne) begin
         nxt.captureFlag = 1'b0; // [R15]
      end
      if (capEdge) begin
         nxt.captureFlag = 1'b1; // [R3]
      end

      // force strobes default low
      nxt.forceA = 1'b0;
      nxt.forceB = 1'b0;

      // cpu writes
      if (bus.wrEn) begin
         if (hitAt(bus.addr, `T16CC_OFF_CTRL_B)) begin
            nxt.ctrlB = bus.wrData & `T16CC_B_WRITE_MASK;
         end else if (hitAt(bus.addr, `T16CC_OFF_CTRL_C)) begin
            // strobes only; matches do not set flags or clear counter
            if (nonPwm(mode)) begin // [R7]
               nxt.forceA = bus.wrData[`T16CC_C_FORCE_A]; // [R8] [R9]
               nxt.forceB = bus.wrData[`T16CC_C_FORCE_B]; // [R8] [R9]
            end
         end else if (hitAt(bus.addr, `T16CC_OFF_COUNT)) begin
            // low byte commits both bytes
            nxt.count = word; // [R11] [R13]
            nxt.blockMatch = 1'b1; // [R12]
         end else if (hitAt(bus.addr, `T16CC_OFF_COUNT + `T16CC_HIGH_STEP)) begin
            nxt.temp = bus.wrData; // [R11] [R13]
         end else if (hitAt(bus.addr, `T16CC_OFF_CAPTURE)) begin
            nxt.capture = word; // [R11] [R13]
         end else if (hitAt(bus.addr, `T16CC_OFF_CAPTURE + `T16CC_HIGH_STEP)) begin
            nxt.temp = bus.wrData; // [R11] [R13]
         end
      end

      // cpu reads
      if (bus.rdEn) begin
         if (hitAt(bus.addr, `T16CC_OFF_CTRL_B)) begin
            rdNext = cur.ctrlB;
         end else if (hitAt(bus.addr, `T16CC_OFF_CTRL_C)) begin
            rdNext = 8'h00; // [R10]
         end else if (hitAt(bus.addr, `T16CC_OFF_COUNT)) begin
            // low read latches high byte
            rdNext = cur.count[7:0]; // [R11] [R13]
            nxt.temp = cur.count[15:8]; // [R11]
         end else if (hitAt(bus.addr, `T16CC_OFF_CAPTURE)) begin
            rdNext = cur.capture[7:0]; // [R11] [R13]
            nxt.temp = cur.capture[15:8]; // [R11]
         end else if (hitAt(bus.addr, `T16CC_OFF_COUNT + `T16CC_HIGH_STEP) ||
                      hitAt(bus.addr, `T16CC_OFF_CAPTURE + `T16CC_HIGH_STEP)) begin
            rdNext = cur.temp; // [R11] [R13]
         end
      end
      nxt.rdData = rdNext;
   end

   // state register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cur <= '0;
         cur.ctrlB <= `T16CC_RST_CTRL_B;
         cur.count <= `T16CC_RST_WORD;
         cur.capture <= `T16CC_RST_WORD;
      end else begin
         cur <= nxt;
      end
   end

   // outputs straight from state
   assign rdData = cur.rdData;
   assign counterValue = cur.count;
   assign waveModeField = {cur.ctrlB[`T16CC_B_MODE3], cur.ctrlB[`T16CC_B_MODE2], 2'b00};
   assign timerTick = cur.timerTick;
   assign matchBlock = cur.blockMatch;
   assign captureFlag = cur.captureFlag;
   assign captureEvent = cur.captureEvent;
   assign forceCompareA = cur.forceA;
   assign forceCompareB = cur.forceB;

endmodule // t16cc_timer
`default_nettype wire

// >>> tb/t16cc_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module t16cc_assertions
   import t16cc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire t16cc_bus_t bus,
   input wire logic [1:0] waveModeLow,
   input wire logic captureVectorAck,
   input wire logic captureFlagWriteOne,
   input wire logic [7:0] rdData,
   input wire logic [15:0] counterValue,
   input wire logic [3:0] waveModeField,
   input wire logic timerTick,
   input wire logic matchBlock,
   input wire logic captureFlag,
   input wire logic captureEvent,
   input wire logic forceCompareA
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // full mode: used by the force gate checks only
   logic [3:0] mode;
   assign mode = {waveModeField[3:2], waveModeLow};
   // one bus write to address a
   sequence s_wr(logic [7:0] a);
      bus.wrEn && bus.addr == a;
   endsequence
   property p_fread;
      bus.rdEn && bus.addr == 8'h82 |=> rdData == 8'h00;
   endproperty
   a_fread: assert property (p_fread) else $error("force bits read back");
   property p_fon;
      s_wr(8'h82) ##0 (bus.wrData[7] && mode[1:0] == 2'b00 && mode != 4'h8) |=> forceCompareA;
   endproperty
   a_fon: assert property (p_fon) else $error("no forced strobe");
   property p_foff;
      s_wr(8'h82) ##0 (mode[1:0] != 2'b00 || mode == 4'h8) |=> !forceCompareA;
   endproperty
   a_foff: assert property (p_foff) else $error("strobe in pwm mode");
   property p_tick;
      timerTick && !$past(bus.wrEn) |-> counterValue == $past(counterValue) + 16'h0001;
   endproperty
   a_tick: assert property (p_tick) else $error("tick without increment");
   property p_bset;
      s_wr(8'h84) |=> matchBlock;
   endproperty
   a_bset: assert property (p_bset) else $error("match not blocked");
   property p_bclr;
      timerTick && !$past(bus.wrEn) |-> !matchBlock;
   endproperty
   a_bclr: assert property (p_bclr) else $error("block outlived tick");
   property p_flag;
      captureEvent |-> captureFlag;
   endproperty
   a_flag: assert property (p_flag) else $error("capture without flag");
   property p_fclr;
      ($past(captureVectorAck) || $past(captureFlagWriteOne)) && !captureEvent |-> !captureFlag;
   endproperty
   a_fclr: assert property (p_fclr) else $error("flag not cleared");
   property p_top;
      (waveModeField[3] && !waveModeLow[0]) [*3] |-> !captureEvent;
   endproperty
   a_top: assert property (p_top) else $error("capture while top");
endmodule // t16cc_assertions
bind t16cc_timer t16cc_assertions i_chk (.*);
`default_nettype wire

// >>> tb/t16cc_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
module t16cc_pin_model (
   input wire logic clk,
   output logic capturePin,
   output logic externalCountPin
);
   // both pins idle low
   initial begin
      capturePin = 1'b0;
      externalCountPin = 1'b0;
   end
   // capture pin to lvl; positive w returns it after w clocks
   task automatic cap_drive(input logic lvl, input int w);
      @(negedge clk);
      capturePin = lvl;
      if (w > 0) begin
         repeat (w) @(negedge clk);
         capturePin = ~lvl;
      end
      repeat (10) @(negedge clk);
   endtask
   // external clock level, held over six clocks
   task automatic ext_step(input logic lvl);
      @(negedge clk);
      externalCountPin = lvl;
      repeat (6) @(negedge clk);
   endtask
endmodule // t16cc_pin_model
`default_nettype wire

// >>> tb/timer16_capture_clock_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
module timer16_capture_clock_control_tb
   import t16cc_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   t16cc_bus_t bus;
   logic [1:0] waveModeLow;
   logic comparatorOut, captureFromComparator, captureVectorAck, captureFlagWriteOne;
   logic capturePin, externalCountPin;
   logic [7:0] rdData, v;
   logic [15:0] counterValue, w;
   logic [3:0] waveModeField;
   logic timerTick, matchBlock, captureFlag, captureEvent, forceCompareA, forceCompareB;
   int error_cnt = 0, tests_run = 0, ticks = 0, caps = 0, fa = 0, fb = 0, cycles = 0, n, n2;
   // address, write data, expected read
   logic [23:0] rows [4] = '{24'h81FFDF, 24'h82C000, 24'h835500, 24'h814040};
   // clocks per tick for each select code; code 0 gives none
   int divs [6] = '{4096, 1, 8, 64, 256, 1024};
   t16cc_timer #(.FILTER_LEN(4)) i_dut (.*);
   t16cc_pin_model i_pins (.*);
   always #50 clk = ~clk;
   // event counters and hang guard, sampled once outputs settle
   always @(posedge clk) begin
      #10;
      cycles++;
      if (timerTick === 1'b1) ticks++;
      if (captureEvent === 1'b1) caps++;
      if (forceCompareA === 1'b1) fa++;
      if (forceCompareB === 1'b1) fb++;
      if (cycles == 20000) begin
         error_cnt++;
         give_verdict();
      end
   end
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      bus = '{a, 1'b1, 1'b0, d};
      @(negedge clk);
      bus.wrEn = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      bus = '{a, 1'b0, 1'b1, 8'h00};
      @(negedge clk);
      bus.rdEn = 1'b0;
      d = rdData;
   endtask
   task automatic wr16(input logic [7:0] a, input logic [15:0] d);
      // high byte first into the shared temp
      wr(a + 8'h01, d[15:8]);
      wr(a, d[7:0]);
   endtask
   task automatic rd16(input logic [7:0] a, output logic [15:0] d);
      rd(a, d[7:0]);
      rd(a + 8'h01, d[15:8]);
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      bus = '0;
      waveModeLow = 2'b00;
      comparatorOut = 1'b0;
      captureFromComparator = 1'b0;
      captureVectorAck = 1'b0;
      captureFlagWriteOne = 1'b0;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      foreach (rows[i]) begin
         wr(rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16], v);
         chk("reg", {8'h00, rows[i][7:0]}, {8'h00, v});
      end
      // second reset mid-run
      @(negedge clk);
      rst = 1'b1;
      @(negedge clk);
      rst = 1'b0;
      rd16(8'h84, w);
      chk("cnt rst", 16'h0000, w);
      wr16(8'h84, 16'h1234); // counter stopped while written
      chk("block", 16'h0001, {15'h0000, matchBlock});
      chk("cnt out", 16'h1234, counterValue);
      rd16(8'h84, w);
      chk("cnt", 16'h1234, w);
      wr(8'h87, 8'hAB);
      wr(8'h84, 8'hCD);
      rd16(8'h84, w);
      chk("temp", 16'hABCD, w);
      wr16(8'h86, 16'h5678);
      rd16(8'h86, w);
      chk("icr", 16'h5678, w);
      // window split evenly by every divider
      for (int k = 0; k < 8; k++) begin
         wr(8'h81, 8'(k));
         repeat (2) @(negedge clk);
         n = ticks;
         if (k < 6) begin
            repeat (2048) @(negedge clk);
            chk("ticks", 16'(2048 / divs[k]), 16'(ticks - n));
         end else begin
            i_pins.ext_step(1'b1);
            chk("ext rise", 16'(k == 7), 16'(ticks - n));
            i_pins.ext_step(1'b0);
            chk("ext both", 16'h0001, 16'(ticks - n));
         end
      end
      // wrong edge then right edge on the falling pass, right edge only on the rising pass; both flag clears
      for (int e = 0; e < 2; e++) begin
         wr(8'h81, 8'(e << 6));
         wr16(8'h84, 16'hBEEF);
         n = caps;
         i_pins.cap_drive(!e[0], 0);
         i_pins.cap_drive(e[0], 0);
         chk("caps", 16'h0001, 16'(caps - n));
         chk("flag", 16'h0001, {15'h0000, captureFlag});
         rd16(8'h86, w);
         chk("held", 16'hBEEF, w);
         @(negedge clk);
         captureVectorAck = e[0];
         captureFlagWriteOne = !e[0];
         @(negedge clk);
         captureVectorAck = 1'b0;
         captureFlagWriteOne = 1'b0;
         @(negedge clk);
         chk("flag clr", 16'h0000, {15'h0000, captureFlag});
      end
      // glitch dropped, steady level taken
      wr(8'h81, 8'hC0);
      n = caps;
      i_pins.cap_drive(1'b0, 0);
      i_pins.cap_drive(1'b1, 2);
      chk("glitch", 16'h0000, 16'(caps - n));
      i_pins.cap_drive(1'b1, 0);
      chk("filt", 16'h0001, 16'(caps - n));
      // capture register as top cuts the pin off
      wr(8'h81, 8'h50);
      i_pins.cap_drive(1'b0, 0);
      n = caps;
      i_pins.cap_drive(1'b1, 0);
      chk("top", 16'h0000, 16'(caps - n));
      // force strobes checked in every mode, expected only in modes 0, 4 and 12
      for (int m = 0; m < 16; m++) begin
         waveModeLow = m[1:0];
         wr(8'h81, {3'b000, m[3:2], 3'b000});
         n = fa;
         n2 = fb;
         wr(8'h82, 8'h80);
         wr(8'h82, 8'h40);
         @(negedge clk);
         chk("mode out", {12'h000, m[3:2], 2'b00}, {12'h000, waveModeField});
         chk("force a", 16'(m % 4 == 0 && m != 8), 16'(fa - n));
         chk("force b", 16'(m % 4 == 0 && m != 8), 16'(fb - n2));
      end
      give_verdict();
   end
endmodule // timer16_capture_clock_control_tb
`default_nettype wire
